// *** dv/pbs_ctl_model.sv ***
// Memory controller model that drives the port's pin side
`timescale 1ns/1ps
module pbs_ctl_model (
    input  wire logic        clk_i,
    output logic [15:0]      pins_o,
    output logic [35:0]      dq_o
);
    // ======================================================================
    // Pins: {cs_a_n, cs_b_n, cs_high, adv, rnw, addr[5:0], bw_n[3:0], susp_n}
    logic [1:0][35:0] d_q;
    logic [1:0]       v_q;

    initial
    begin
        pins_o = 16'hA01F;
        dq_o   = 36'h0_0000_0000;
        v_q    = 2'h0;
    end

    // Lane selects go out with the address, data two taken edges later
    task drive(input logic [2:0] cs, input logic adv, input logic rnw, input logic [5:0] a,
               input logic [3:0] bw, input logic cn, input logic [35:0] wd, input logic wv);
        @(posedge clk_i);
        pins_o <= {cs, adv, rnw, a, bw, cn};
        if (!cn)
        begin
            // Undriven data shows the inverse so a stale value cannot match
            dq_o <= v_q[1] ? d_q[1] : ~dq_o;
            d_q = {d_q[0], wd};
            v_q = {v_q[0], wv};
        end
        #10;
    endtask
endmodule

// *** dv/pipelined_burst_sram_port_test.sv ***
// Self-checking bench for the pipelined burst SRAM port
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module pipelined_burst_sram_port_test;
    localparam logic [2:0] SEL = 3'h1;
    localparam logic [2:0] DES = 3'h5;
    logic        clk = 1'b0;
    logic        rst_n, oe_n, slp, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [15:0] pins;
    logic [35:0] dq_i, dq_o, mem [64];
    logic        dq_oe, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    int          bad_count = 0, checks_done = 0, cyc = 0, nloads = 0, n, m;

    pbs_ctl_model i_pbs_ctl_model (.clk_i(clk), .pins_o(pins), .dq_o(dq_i));
    pbs_sram_port #(.AW(6)) i_pbs_sram_port (
        .CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(pins[10:5]),
        .READ_NOT_WRITE_I(pins[11]), .ADVANCE_OR_LOAD_I(pins[12]),
        .CHIP_SELECT_A_N_I(pins[15]), .CHIP_SELECT_B_N_I(pins[14]),
        .CHIP_SELECT_HIGH_I(pins[13]), .CLOCK_SUSPEND_N_I(pins[0]),
        .BYTE_LANE_WRITE_N_I(pins[4:1]), .OUTPUT_ENABLE_N_I(oe_n),
        .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE_O(dq_oe),
        .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready),
        .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(wvalid),
        .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid),
        .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid),
        .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
        .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready));

    // ======================================================================
    // Helpers
    always #(pbs_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            results;
        end
    end

    function automatic logic [35:0] dat(input logic [5:0] a);
        dat = {a, ~a, a, ~a, a, ~a};
    endfunction

    function automatic logic [5:0] ba(input logic [5:0] b, input int k, input logic o);
        ba = {b[5:2], o ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k)};
    endfunction

    function automatic logic [35:0] mrg(input logic [35:0] o, input logic [35:0] d,
                                        input logic [3:0] bw);
        mrg = o;
        for (int i = 0; i < 4; i++)
            if (!bw[i])
                mrg[9*i +: 9] = d[9*i +: 9];
    endfunction

    task results;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task op(input logic [2:0] cs, input logic adv, input logic rnw, input logic [5:0] a,
            input logic [3:0] bw, input logic cn, input logic [35:0] wd, input logic wv);
        if (cs == SEL && !adv && !cn && !slp)
            nloads++;
        i_pbs_ctl_model.drive(cs, adv, rnw, a, bw, cn, wd, wv);
    endtask

    task des;
        op(DES, 1'b0, 1'b1, 6'h00, 4'hF, 1'b0, 36'h0_0000_0000, 1'b0);
    endtask

    task rd1(input logic [5:0] a);
        op(SEL, 1'b0, 1'b1, a, 4'hF, 1'b0, 36'h0_0000_0000, 1'b0);
        des;
        des;
        `CHK("rd1 drive", 1'b1, dq_oe)
        `CHK("rd1 data", mem[a], dq_o)
    endtask

    task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Loop test sees this edge's values, so the exit comes one edge late
        do
        begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bready && bvalid)
            begin
                `CHK("bresp", r, bresp)
                bready <= 1'b0;
            end
        end
        while (awvalid || wvalid || bready);
    endtask

    task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rready && rvalid)
            begin
                `CHK("rdata", d, rdata)
                `CHK("rresp", r, rresp)
                rready <= 1'b0;
            end
        end
        while (arvalid || rready);
    endtask

    // ======================================================================
    // Sequence
    initial
    begin
        {rst_n, oe_n, slp, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
        {awaddr, araddr, wdata} = 48'h0000_0000_0000;
        repeat (5) @(posedge clk);
        `CHK("reset float", 1'b0, dq_oe)
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        axr(pbs_pkg::REG_CTRL, 32'h0000_0001, pbs_pkg::RESP_OKAY);
        axr(8'h10, 32'h0000_0000, pbs_pkg::RESP_SLVERR);
        axw(8'h10, 32'h0000_0000, pbs_pkg::RESP_SLVERR);
        // Back-to-back single writes: data lands beside the load two after it
        for (int a = 0; a < 16; a++)
        begin
            mem[a] = dat(6'(a));
            op(SEL, 1'b0, 1'b0, 6'(a), 4'h0, 1'b0, mem[a], 1'b1);
        end
        des;
        des;
        // Read bursts in both orders; advances offer a write to tempt a turn
        for (int o = 1; o >= 0; o--)
        begin
            axw(pbs_pkg::REG_CTRL, 32'(o), pbs_pkg::RESP_OKAY);
            for (int i = 0; i < 8; i++)
            begin
                op(i < 5 ? SEL : DES, i > 0 && i < 5, i == 0, 6'h05, 4'h0, 1'b0,
                   36'h0_0000_0000, 1'b1);
                if (i >= 2)
                    `CHK("drive", 1'(i < 7), dq_oe)
                if (i >= 2 && i < 7)
                    `CHK("burst", mem[ba(6'h05, i - 2, 1'(o))], dq_o)
            end
        end
        // Linear burst write on two lanes, read/write high on advances
        for (int i = 0; i < 6; i++)
        begin
            if (i < 4)
                mem[ba(6'h0A, i, 1'b0)] = mrg(mem[ba(6'h0A, i, 1'b0)],
                                              ~dat(ba(6'h0A, i, 1'b0)), 4'hA);
            op(i < 4 ? SEL : DES, i > 0 && i < 4, i > 0, 6'h0A, 4'hA, 1'b0,
               ~dat(ba(6'h0A, i, 1'b0)), i < 4);
        end
        op(SEL, 1'b0, 1'b0, 6'h0C, 4'hF, 1'b0, 36'h0_0000_0000, 1'b1);
        des;
        des;
        for (int a = 8; a < 13; a++)
            rd1(6'(a));
        // Each enable false in turn, then sleep: no write may happen
        for (int j = 0; j < 4; j++)
        begin
            if (j == 3)
            begin
                slp = 1'b1;
                axw(pbs_pkg::REG_CTRL, 32'h0000_0002, pbs_pkg::RESP_OKAY);
            end
            op(j == 3 ? SEL : SEL ^ (3'h4 >> j), 1'b0, 1'b0, 6'h0D, 4'h0, 1'b0,
               36'h0_0000_0000, 1'b1);
            des;
            des;
        end
        slp = 1'b0;
        axw(pbs_pkg::REG_CTRL, 32'h0000_0001, pbs_pkg::RESP_OKAY);
        rd1(6'h0D);
        // Suspended edges carry a fresh load that must be ignored
        op(SEL, 1'b0, 1'b1, 6'h03, 4'hF, 1'b0, 36'h0_0000_0000, 1'b0);
        repeat (3)
            op(SEL, 1'b0, 1'b1, 6'h07, 4'hF, 1'b1, 36'h0_0000_0000, 1'b0);
        des;
        `CHK("suspend hold", 1'b0, dq_oe)
        des;
        `CHK("suspend data", mem[3], dq_o)
        // Output enable pulse in mid-burst must not upset the counter
        for (int i = 0; i < 11; i++)
        begin
            op(SEL, i > 0, 1'b1, 6'h00, 4'hF, 1'b0, 36'h0_0000_0000, 1'b0);
            if (i == 3 || i == 6)
                oe_n <= (i == 3);
            if (i == 7)
                `CHK("oe float", 1'b0, dq_oe)
            if (i == 10)
                `CHK("oe data", mem[ba(6'h00, 8, 1'b1)], dq_o)
        end
        des;
        `CHK("oe back", 1'b1, dq_oe)
        des;
        // Read-back buffer keeps the word while the receiver stalls
        @(posedge clk);
        araddr <= pbs_pkg::REG_LOADS;
        arvalid <= 1'b1;
        n = 0;
        m = 0;
        repeat (6)
        begin
            @(posedge clk);
            if (arvalid && arready)
            begin
                n++;
                arvalid <= 1'b0;
            end
        end
        rready <= 1'b1;
        repeat (4)
        begin
            @(posedge clk);
            if (rvalid && rready)
            begin
                m++;
                `CHK("load count", 32'(nloads), rdata)
                rready <= 1'b0;
            end
        end
        `CHK("buffer taken", 1, n)
        `CHK("buffer drained", 1, m)
        results;
    end
endmodule

// *** src/pbs_pair_buf.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module pbs_pair_buf #(
    parameter int W = 34
) (
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    pbs_stream_if.snk   fill,
    pbs_stream_if.src   drain
);
    typedef struct packed {
        logic [W-1:0] e0;
        logic [W-1:0] e1;
        logic         v0;
        logic         v1;
        logic         nf;
    } pbs_buf_st_t;

    pbs_buf_st_t q;
    pbs_buf_st_t n;

    // ======================================================================
    // Shift on pop, fill lowest free slot on push
    always_comb
    begin
        n = q;
        if (q.v0 && drain.ready)
        begin
            n.e0 = q.e1;
            n.v0 = q.v1;
            n.v1 = 1'b0;
        end
        // Ready is the registered not-full bit, so a full pair refuses a word
        if (fill.valid && !q.v1)
        begin
            if (!n.v0)
            begin
                n.e0 = fill.data;
                n.v0 = 1'b1;
            end
            else
            begin
                n.e1 = fill.data;
                n.v1 = 1'b1;
            end
        end
        n.nf = ~n.v1;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            q    <= '0;
            q.nf <= 1'b1;
        end
        else
            q <= n;
    end

    assign fill.ready  = q.nf;
    assign drain.valid = q.v0;
    assign drain.data  = q.e0;
endmodule

// *** src/pbs_pkg.sv ***
// Constants shared by the pipelined burst SRAM port and its helpers
// ==========================================================================
// Operation
// RQ1: Write data arrives two cycles after its load, even beside a deselect or load.
// RQ2: Data outputs stay high impedance from the first edge until a read drives them.
// RQ3: A burst steps only the two lowest address bits through four words.
// RQ4: Advance-or-load sampled low ends a burst and loads the new address and control.
// RQ5: Read/write is ignored while advancing; direction stays as loaded.
// RQ6: Controller presents byte write selects with address, two cycles before data.
// RQ7: Read/write low in a selected load starts a write, high starts a read.
// RQ8: Clock suspend high makes the edge vanish; every internal register holds. The output enable stages and the driver enable still update.
// RQ9: Selected only with both low enables low and the high enable high.
// RQ10: Burst order defaults to interleaved and sleep defaults off.
// RQ11: The burst counter wraps after four words and keeps counting.
// RQ12: Interleaved order XORs the start with the count; linear adds modulo four.
// RQ13: Read data drives the bus two cycles after its load while output enable is low.
// RQ14: Each low byte select writes one lane with its parity bit; all high writes none.
// RQ15: Output enable high forces high impedance without touching pipeline or counter.
// RQ16: A deselect starts nothing, lets pending work finish, bus floats two cycles later.
package pbs_pkg;
    // ======================================================================
    // Memory geometry
    localparam int ADDR_W = 18;
    localparam int LANES  = 4;
    localparam int LANE_W = 9;
    localparam int CNT_W  = 2;

    // ======================================================================
    // Register map
    localparam int          AXI_AW      = 8;
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_STATUS  = 8'h04;
    localparam logic [7:0]  REG_LOADS   = 8'h08;
    localparam int          CTRL_ORDER_POS = 0;
    localparam int          CTRL_SLEEP_POS = 1;
    localparam logic        CTRL_ORDER_RST = 1'h1;
    localparam logic        CTRL_SLEEP_RST = 1'h0;
    localparam int          STAT_ACT_POS   = 0;
    localparam int          STAT_WR_POS    = 1;
    localparam int          STAT_CNT_POS   = 2;
    localparam int          STAT_SLEEP_POS = 4;
    localparam int          STAT_DRIVE_POS = 5;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ======================================================================
    // Clock
    localparam int CLK_PERIOD_NS = 100;
endpackage

// *** src/pbs_sram_port.sv ***
// Pipelined burst SRAM port with byte writes and an AXI4-Lite control slave
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module pbs_sram_port #(
    parameter int AW = pbs_pkg::ADDR_W,
    parameter int NB = pbs_pkg::LANES,
    parameter int LW = pbs_pkg::LANE_W
) (
    input  wire logic                         CLK_I,
    input  wire logic                         RST_N_I,
    input  wire logic [AW-1:0]                ADDR_I,
    input  wire logic                         READ_NOT_WRITE_I,
    input  wire logic                         ADVANCE_OR_LOAD_I,
    input  wire logic                         CHIP_SELECT_A_N_I,
    input  wire logic                         CHIP_SELECT_B_N_I,
    input  wire logic                         CHIP_SELECT_HIGH_I,
    input  wire logic                         CLOCK_SUSPEND_N_I,
    input  wire logic [NB-1:0]                BYTE_LANE_WRITE_N_I,
    input  wire logic                         OUTPUT_ENABLE_N_I,
    input  wire logic [NB*LW-1:0]             DQ_I,
    output logic      [NB*LW-1:0]             DQ_O,
    output logic                              DQ_OE_O,
    input  wire logic [pbs_pkg::AXI_AW-1:0]   AXI_AWADDR_I,
    input  wire logic                         AXI_AWVALID_I,
    output logic                              AXI_AWREADY_O,
    input  wire logic [31:0]                  AXI_WDATA_I,
    input  wire logic [3:0]                   AXI_WSTRB_I,
    input  wire logic                         AXI_WVALID_I,
    output logic                              AXI_WREADY_O,
    output logic [1:0]                        AXI_BRESP_O,
    output logic                              AXI_BVALID_O,
    input  wire logic                         AXI_BREADY_I,
    input  wire logic [pbs_pkg::AXI_AW-1:0]   AXI_ARADDR_I,
    input  wire logic                         AXI_ARVALID_I,
    output logic                              AXI_ARREADY_O,
    output logic [31:0]                       AXI_RDATA_O,
    output logic [1:0]                        AXI_RRESP_O,
    output logic                              AXI_RVALID_O,
    input  wire logic                         AXI_RREADY_I
);
    localparam int DW = NB * LW;
    localparam int CW = pbs_pkg::CNT_W;
    localparam int BA = pbs_pkg::AXI_AW;

    typedef struct packed {
        logic          vld;
        logic          wr;
        logic [AW-1:0] addr;
        logic [NB-1:0] bw_n;
    } pbs_stage_t;

    typedef struct packed {
        logic          act;
        logic          wr;
        logic [AW-1:0] base;
        logic [CW-1:0] cnt;
    } pbs_burst_t;

    typedef struct packed {
        pbs_stage_t    s1;
        pbs_stage_t    s2;
        pbs_burst_t    bst;
        logic [DW-1:0] dq;
        logic          drive;
        logic          dq_oe;
        logic          oe_s1;
        logic          oe_s2;
        logic          order;
        logic          sleep;
        logic [15:0]   loads;
        logic          aw_h;
        logic [BA-1:0] awaddr;
        logic          w_h;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          awrdy;
        logic          wrdy;
        logic          bvalid;
        logic [1:0]    bresp;
    } pbs_state_t;

    pbs_state_t    q;
    pbs_state_t    n;
    logic [DW-1:0] mem [2**AW];
    logic          sel_w;
    logic          take_w;
    logic          adv_w;
    logic          susp_w;
    logic [DW-1:0] rd_word;

    pbs_stream_if #(.W(34)) rd_fill ();
    pbs_stream_if #(.W(34)) rd_drain ();

    // ======================================================================
    // Helpers
    function automatic logic [CW-1:0] burst_low(input logic [CW-1:0] start,
                                               input logic [CW-1:0] cnt,
                                               input logic          ilv);
        // Sum wraps modulo four by its width
        burst_low = ilv ? (start ^ cnt) : CW'(start + cnt);      // [RQ12]
    endfunction

    function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_w,
                                                input logic [DW-1:0] new_w,
                                                input logic [NB-1:0] bw_n);
        logic [DW-1:0] r;
        r = old_w;
        for (int i = 0; i < NB; i++)
        begin
            if (!bw_n[i])
                r[i*LW +: LW] = new_w[i*LW +: LW];               // [RQ14]
        end
        return r;
    endfunction

    function automatic logic [BA-1:0] word_of(input logic [BA-1:0] a);
        word_of = {a[BA-1:2], 2'h0};
    endfunction

    function automatic logic [33:0] reg_read(input logic [BA-1:0] a,
                                             input pbs_state_t   s);
        logic [31:0] d;
        logic [1:0]  r;
        d = 32'h0000_0000;
        r = pbs_pkg::RESP_OKAY;
        if (word_of(a) == pbs_pkg::REG_CTRL)
        begin
            d[pbs_pkg::CTRL_ORDER_POS] = s.order;
            d[pbs_pkg::CTRL_SLEEP_POS] = s.sleep;
        end
        else if (word_of(a) == pbs_pkg::REG_STATUS)
        begin
            d[pbs_pkg::STAT_ACT_POS]             = s.bst.act;
            d[pbs_pkg::STAT_WR_POS]              = s.bst.wr;
            d[pbs_pkg::STAT_CNT_POS +: CW]       = s.bst.cnt;
            d[pbs_pkg::STAT_SLEEP_POS]           = s.sleep;
            d[pbs_pkg::STAT_DRIVE_POS]           = s.drive;
        end
        else if (word_of(a) == pbs_pkg::REG_LOADS)
            d[15:0] = s.loads;
        else
            r = pbs_pkg::RESP_SLVERR;
        return {r, d};
    endfunction

    // ======================================================================
    // Pin decode
    assign sel_w  = ~CHIP_SELECT_A_N_I & ~CHIP_SELECT_B_N_I
                  & CHIP_SELECT_HIGH_I & ~q.sleep;              // [RQ9]
    assign take_w = ~ADVANCE_OR_LOAD_I & sel_w;
    assign adv_w  = ADVANCE_OR_LOAD_I;
    assign susp_w = CLOCK_SUSPEND_N_I;

    // A write still in the second stage lands on the same edge, so forward it
    always_comb
    begin
        rd_word = mem[q.s1.addr];
        if (q.s2.vld && q.s2.wr && q.s2.addr == q.s1.addr)
            rd_word = lane_merge(rd_word, DQ_I, q.s2.bw_n);
    end

    // ======================================================================
    // Next state
    always_comb
    begin
        logic [33:0] look;
        look = '0;
        n = q;
        n.oe_s1 = OUTPUT_ENABLE_N_I;
        n.oe_s2 = q.oe_s1;
        if (!susp_w)                                            // [RQ8]
        begin
            n.s2      = q.s1;
            n.s1.bw_n = BYTE_LANE_WRITE_N_I;                    // [RQ6]
            if (!adv_w)
            begin
                // Load ends any burst; a deselect leaves nothing new behind [RQ4] [RQ16]
                n.s1.vld   = take_w;
                n.s1.wr    = ~READ_NOT_WRITE_I;                 // [RQ7]
                n.s1.addr  = ADDR_I;
                n.bst.act  = take_w;
                n.bst.wr   = ~READ_NOT_WRITE_I;
                n.bst.base = ADDR_I;
                n.bst.cnt  = '0;
            end
            else
            begin
                // Direction comes from the load, never from the pin now [RQ5]
                if (q.bst.act)
                    n.bst.cnt = CW'(q.bst.cnt + 1'b1);          // [RQ11]
                n.s1.vld  = q.bst.act;
                n.s1.wr   = q.bst.wr;
                n.s1.addr = {q.bst.base[AW-1:CW],
                             burst_low(q.bst.base[CW-1:0], n.bst.cnt, q.order)}; // [RQ3]
            end
            if (take_w)
                n.loads = q.loads + 16'h0001;
            n.dq    = rd_word;
            n.drive = q.s1.vld & ~q.s1.wr;                      // [RQ13]
        end
        // Output enable gates only the driver, never the pipeline
        n.dq_oe = n.drive & ~q.oe_s2 & ~q.sleep;               // [RQ15]

        if (AXI_AWVALID_I && q.awrdy)
        begin
            n.aw_h   = 1'b1;
            n.awaddr = AXI_AWADDR_I;
        end
        if (AXI_WVALID_I && q.wrdy)
        begin
            n.w_h   = 1'b1;
            n.wdata = AXI_WDATA_I;
            n.wstrb = AXI_WSTRB_I;
        end
        if (q.bvalid && AXI_BREADY_I)
            n.bvalid = 1'b0;
        if (n.aw_h && n.w_h && !n.bvalid)
        begin
            n.aw_h   = 1'b0;
            n.w_h    = 1'b0;
            n.bvalid = 1'b1;
            look     = reg_read(n.awaddr, q);
            n.bresp  = look[33:32];
            if (word_of(n.awaddr) == pbs_pkg::REG_CTRL && n.wstrb[0])
            begin
                n.order = n.wdata[pbs_pkg::CTRL_ORDER_POS];
                n.sleep = n.wdata[pbs_pkg::CTRL_SLEEP_POS];
            end
        end
        n.awrdy = ~n.aw_h & ~n.bvalid;
        n.wrdy  = ~n.w_h & ~n.bvalid;
    end

    // ======================================================================
    // State and memory
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            q       <= '0;                                      // [RQ2]
            q.order <= pbs_pkg::CTRL_ORDER_RST;                 // [RQ10]
            q.sleep <= pbs_pkg::CTRL_SLEEP_RST;
            q.awrdy <= 1'b1;
            q.wrdy  <= 1'b1;
        end
        else
            q <= n;
    end

    // Memory is not reset; a suspended edge writes nothing
    always_ff @(posedge CLK_I)
    begin
        if (!susp_w && q.s2.vld && q.s2.wr)
            mem[q.s2.addr] <= lane_merge(mem[q.s2.addr], DQ_I, q.s2.bw_n); // [RQ1]
    end

    // ======================================================================
    // Register read-back through the pair buffer
    assign rd_fill.valid = AXI_ARVALID_I;
    assign rd_fill.data  = reg_read(AXI_ARADDR_I, q);

    pbs_pair_buf #(
        .W (34)
    ) u_rd_buf (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .fill    (rd_fill),
        .drain   (rd_drain)
    );

    assign rd_drain.ready = AXI_RREADY_I;
    assign AXI_ARREADY_O  = rd_fill.ready;
    assign AXI_RVALID_O   = rd_drain.valid;
    assign AXI_RDATA_O    = rd_drain.data[31:0];
    assign AXI_RRESP_O    = rd_drain.data[33:32];
    assign DQ_O           = q.dq;
    assign DQ_OE_O        = q.dq_oe;
    assign AXI_AWREADY_O  = q.awrdy;
    assign AXI_WREADY_O   = q.wrdy;
    assign AXI_BVALID_O   = q.bvalid;
    assign AXI_BRESP_O    = q.bresp;

    // ======================================================================
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    wr_pipe_a: // [RQ1]
        assert property ((take_w && !READ_NOT_WRITE_I && !susp_w) ##1 !susp_w
                         |=> q.s2.vld && q.s2.wr)
        else $error("write did not reach the data stage two edges after load");

    pwr_hiz_a: // [RQ2]
        assert property (@(posedge CLK_I) disable iff (1'b0) !RST_N_I |=> !DQ_OE_O)
        else $error("data bus driven during or right after reset");

    hi_bits_a: // [RQ3]
        assert property ((adv_w && q.bst.act && !susp_w)
                         |=> q.s1.addr[AW-1:CW] == q.bst.base[AW-1:CW])
        else $error("burst changed address bits above the low pair");

    burst_end_a: // [RQ4]
        assert property ((take_w && !susp_w)
                         |=> q.s1.vld && q.s1.addr == $past(ADDR_I) && q.bst.cnt == '0)
        else $error("load did not take the new address");

    dir_hold_a: // [RQ5]
        assert property ((adv_w && q.bst.act && !susp_w)
                         |=> q.s1.wr == $past(q.bst.wr) && $stable(q.bst.wr))
        else $error("burst direction followed the read/write pin");

    wr_start_a: // [RQ7]
        assert property ((take_w && !susp_w) |=> q.s1.wr == !$past(READ_NOT_WRITE_I))
        else $error("load started the wrong operation");

    susp_hold_a: // [RQ8]
        assert property (susp_w |=> $stable(q.s1) && $stable(q.s2) && $stable(q.bst)
                         && $stable(DQ_O))
        else $error("suspended edge changed internal state");

    chip_sel_a: // [RQ9]
        assert property ((!adv_w && !susp_w && (CHIP_SELECT_A_N_I || CHIP_SELECT_B_N_I
                         || !CHIP_SELECT_HIGH_I)) |=> !q.s1.vld && !q.bst.act)
        else $error("operation started without full selection");

    dflt_ctrl_a: // [RQ10]
        assert property (@(posedge CLK_I) disable iff (1'b0)
                         !RST_N_I |=> q.order && !q.sleep)
        else $error("control defaults wrong after reset");

    wrap_a: // [RQ11]
        assert property ((adv_w && q.bst.act && q.bst.cnt == 2'h3 && !susp_w)
                         |=> q.bst.cnt == 2'h0 && q.s1.addr[1:0] == q.bst.base[1:0])
        else $error("burst counter did not wrap to the start");

    order_step_a: // [RQ12]
        assert property ((adv_w && q.bst.act && !susp_w && q.order && $stable(q.order))
                         |=> q.s1.addr[1:0] == (q.bst.base[1:0] ^ q.bst.cnt))
        else $error("interleaved step wrong");

    rd_latency_a: // [RQ13]
        assert property ((take_w && READ_NOT_WRITE_I && !susp_w)
                         ##1 (!susp_w && !q.oe_s2 && !q.sleep)
                         |=> DQ_OE_O && DQ_O == $past(rd_word))
        else $error("read data not driven two cycles after load");

    oe_hiz_a: // [RQ15]
        assert property (q.oe_s2 |=> !DQ_OE_O)
        else $error("bus driven while output enable high");

    desel_a: // [RQ16]
        assert property ((!adv_w && !sel_w && !susp_w) ##1 !susp_w |=> !DQ_OE_O)
        else $error("bus still driven two cycles after deselect");
endmodule

// *** src/pbs_stream_if.sv ***
// Valid/ready word stream between the port and its read-back buffer
`timescale 1ns/1ps
interface pbs_stream_if #(
    parameter int W = 34
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
